/* File: rtl/sms_map.svh */
/*
 * offsets, reset values and timing counts of the mode supervisor.
 * assumes a 20 MHz ref_clk; included by bare name.
 */
`ifndef SMS_MAP_SVH
`define SMS_MAP_SVH
`define SMS_CLK_HZ         20000000
`define SMS_NRQ_TIME_MS    350
`define SMS_NRQ_CYCLES     ((`SMS_NRQ_TIME_MS * `SMS_CLK_HZ) / 1000)
`define SMS_IRQ_PULSE_US   10
`define SMS_IRQ_PULSE_CYC  ((`SMS_IRQ_PULSE_US * `SMS_CLK_HZ) / 1000000)
`define SMS_RST_DUR_CYC    1000
`define SMS_HS_PERIOD_CYC  2000
`define SMS_HS_ON_CYC      100
`define SMS_FRAME_BITS     8
`define SMS_SYNC_IDLE      16'h300F
`define SMS_CMD_MODE       4'h1
`define SMS_CMD_WDOG       4'h2
`define SMS_CMD_HSW        4'h3
`define SMS_CMD_CLR        4'h4
`define SMS_CMD_READ_IO    4'h5
`define SMS_CMD_READ_IRQ   4'h6
`define SMS_CMD_READ_MCR   4'h7
`define SMS_CMD_IRQ_EN     4'h8
`endif

/* File: rtl/sms_pkg.sv */
/*
 * types of the mode supervisor.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package sms_pkg;
  typedef enum logic [2:0] {
    SMS_RESET, SMS_NORMAL_REQ, SMS_NORMAL, SMS_STANDBY, SMS_STOP, SMS_SLEEP
  } sms_mode_e;
  typedef struct packed {
    logic main_uv;
    logic main_temp_warn;
    logic batt_loss;
    logic batt_low;
    logic aux_low;
    logic hs_overtemp;
  } sms_analog_s;
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic cs_n;
  } sms_spi_s;
endpackage

/* File: rtl/sms_mode_supervisor.sv */
/*
 * digital core of the mode supervisor: serial port, bus pin mapping,
 * reset, interrupt and fault outputs, status flags, high-side switch,
 * wake inputs, oscillator choice and mode sequencing.
 * assumes analog comparators deliver raw levels; every pin input is
 * asynchronous to ref_clk; all but wdog_misservice are synchronised here.
 */
`include "sms_map.svh"
// What this block does
// - sample serial input on clock falling edge
// - shift serial output on clock rising edge
// - serial port active only while select low
// - transmit low drives bus dominant
// - receive low while bus dominant
// - reset output low in reset mode
// - main undervoltage forces reset output low
// - temperature warning sets control and irq flags
// - enabled irq holds line low until cleared
// - stop mode wake gives 10 us pulse
// - fault output low on watchdog misservice
// - battery loss flag latched in all modes
// - battery low irq only normal or standby
// - aux supply low flag reports aux state
// - switch overtemp sets io and irq flags
// - switch from register, periodic in low power
// - wake inputs readable and wake low power
// - slow oscillator in sleep and stop
// - modes by command, normal request automatic
// - standby keeps ballast drive off
// - normal enables both regulators, watchdog serviced
// - stop entered at select rising edge
// - 350 ms timer stopped by watchdog write
// - reset timer then normal request
module sms_mode_supervisor (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire sms_pkg::sms_spi_s    spi_in,
  output logic                      spi_miso,
  output logic                      spi_miso_oe,
  input  wire logic                 bus_transmit_in,
  output logic                      bus_receive_out,
  output logic                      bus_drive_dominant,
  input  wire logic                 bus_dominant_in,
  input  wire logic                 bus_wake_in,
  input  wire sms_pkg::sms_analog_s analog_in,
  input  wire logic [3:0]           wake_inputs,
  input  wire logic                 wdog_misservice,
  output logic                      sys_reset_out_n,
  output logic                      irq_out_n,
  output logic                      supervisor_fault_out_n,
  output logic                      high_side_switch,
  output logic                      ballast_drive_out,
  output logic                      main_regulator_on,
  output logic                      slow_osc_sel,
  output sms_pkg::sms_mode_e        mode
);
  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  localparam int NSYNC = 16;
  // idle level of each pin, so no false edge or flag follows reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = `SMS_SYNC_IDLE;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  assign raw = {spi_in.sclk, spi_in.mosi, spi_in.cs_n, bus_transmit_in,
                bus_dominant_in, bus_wake_in, analog_in, wake_inputs};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          s1_q[gi] <= SYNC_IDLE[gi];
          s2_q[gi] <= SYNC_IDLE[gi];
        end else begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate
  logic sclk_s, mosi_s, cs_n_s, txd_s, bdom_s, bwake_s;
  sms_pkg::sms_analog_s an_s;
  logic [3:0] wake_s;
  assign {sclk_s, mosi_s, cs_n_s, txd_s, bdom_s, bwake_s, an_s, wake_s} =
         s2_q;

  // ****************************************************************
  // bus pin mapping
  // ****************************************************************
  assign bus_drive_dominant = ~txd_s;
  assign bus_receive_out    = ~bdom_s;

  // ****************************************************************
  // serial port
  // ****************************************************************
  logic sclk_d1_q, cs_d1_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sclk_d1_q <= 1'b0;
      cs_d1_q   <= 1'b1;
    end else begin
      sclk_d1_q <= sclk_s;
      cs_d1_q   <= cs_n_s;
    end
  end
  logic sclk_fall, sclk_rise, cs_rise, cs_fall;
  assign sclk_fall = sclk_d1_q & ~sclk_s & ~cs_n_s;
  assign sclk_rise = ~sclk_d1_q & sclk_s & ~cs_n_s;
  assign cs_rise   = ~cs_d1_q & cs_n_s;
  assign cs_fall   = cs_d1_q & ~cs_n_s;

  logic [7:0] rx_q, tx_q, rdata;
  logic [3:0] bits_q;
  always_ff @(posedge ref_clk) begin
    if (rst || cs_fall) begin
      rx_q   <= 8'h00;
      bits_q <= 4'h0;
    end else if (sclk_fall) begin
      rx_q   <= {rx_q[6:0], mosi_s};
      bits_q <= bits_q + 4'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_q <= 8'h00;
    end else if (cs_fall) begin
      tx_q <= rdata;
    end else if (sclk_rise) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end
  assign spi_miso    = tx_q[7];
  assign spi_miso_oe = ~cs_n_s;

  logic       frame_end;
  logic [3:0] cmd;
  logic [3:0] arg;
  assign frame_end = cs_rise && (bits_q == 4'(`SMS_FRAME_BITS));
  assign cmd = rx_q[7:4];
  assign arg = rx_q[3:0];

  // ****************************************************************
  // status flags and registers
  // ****************************************************************
  logic [2:0] irq_flags_q; // {hs_overtemp, batt_low, temp_warn}
  logic [2:0] irq_en_q;
  logic       regulator_temp_warning_flag_q;
  logic       battery_loss_flag_q;
  logic       hs_ctrl_q;
  logic       clr_hit;
  logic [2:0] irq_set;
  assign clr_hit = frame_end && (cmd == `SMS_CMD_CLR);
  assign irq_set[0] = an_s.main_temp_warn;
  assign irq_set[1] = an_s.batt_low &&
                      (mode == sms_pkg::SMS_NORMAL ||
                       mode == sms_pkg::SMS_STANDBY);
  assign irq_set[2] = an_s.hs_overtemp;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_irq
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          irq_flags_q[gi] <= 1'b0;
        end else if (irq_set[gi]) begin
          irq_flags_q[gi] <= 1'b1;
        end else if (clr_hit && arg[gi]) begin
          irq_flags_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regulator_temp_warning_flag_q <= 1'b0;
    end else if (an_s.main_temp_warn) begin
      regulator_temp_warning_flag_q <= 1'b1;
    end else if (clr_hit && arg[0]) begin
      regulator_temp_warning_flag_q <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      battery_loss_flag_q <= 1'b1;
    end else if (an_s.batt_loss) begin
      battery_loss_flag_q <= 1'b1;
    end else if (clr_hit && arg[3]) begin
      battery_loss_flag_q <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_en_q  <= 3'h0;
      hs_ctrl_q <= 1'b0;
    end else if (frame_end && cmd == `SMS_CMD_IRQ_EN) begin
      irq_en_q <= arg[2:0];
    end else if (frame_end && cmd == `SMS_CMD_HSW) begin
      hs_ctrl_q <= arg[0];
    end
  end
  // read data: io {wake, aux_low, hs_ot, batt_low, 0}; irq in low bits; mcr {batt_loss, 0, mode, temp_warn}
  always_comb begin
    unique case (cmd)
      `SMS_CMD_READ_IO:  rdata = {wake_s, an_s.aux_low,
                                  an_s.hs_overtemp, an_s.batt_low, 1'b0};
      `SMS_CMD_READ_IRQ: rdata = {5'h00, irq_flags_q};
      `SMS_CMD_READ_MCR: rdata = {battery_loss_flag_q, 3'h0,
                                  mode, regulator_temp_warning_flag_q};
      default:           rdata = {battery_loss_flag_q, 7'h00};
    endcase
  end

  // ****************************************************************
  // mode sequencing
  // ****************************************************************
  logic [23:0] tmr_q;
  logic        from_sleep_q;
  logic        wake_ev;
  logic        tmr_done;
  assign wake_ev  = bwake_s || (wake_s != 4'hF);
  assign tmr_done = (tmr_q == 24'h000000);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode         <= sms_pkg::SMS_RESET;
      tmr_q        <= 24'(`SMS_RST_DUR_CYC);
      from_sleep_q <= 1'b0;
    end else if (an_s.main_uv && mode != sms_pkg::SMS_SLEEP) begin
      mode  <= sms_pkg::SMS_RESET;
      tmr_q <= 24'(`SMS_RST_DUR_CYC);
    end else begin
      if (!tmr_done) begin
        tmr_q <= tmr_q - 24'h000001;
      end
      unique case (mode)
        sms_pkg::SMS_RESET: if (tmr_done) begin
          mode  <= sms_pkg::SMS_NORMAL_REQ;
          tmr_q <= 24'(`SMS_NRQ_CYCLES);
        end
        sms_pkg::SMS_NORMAL_REQ: begin
          if (frame_end && cmd == `SMS_CMD_WDOG) begin
            mode <= arg[0] ? sms_pkg::SMS_STANDBY
                           : sms_pkg::SMS_NORMAL;
            from_sleep_q <= 1'b0;
          end else if (tmr_done) begin
            mode  <= from_sleep_q ? sms_pkg::SMS_SLEEP : sms_pkg::SMS_RESET;
            tmr_q <= 24'(`SMS_RST_DUR_CYC);
          end
        end
        sms_pkg::SMS_NORMAL, sms_pkg::SMS_STANDBY: begin
          if (frame_end && cmd == `SMS_CMD_MODE) begin
            unique case (arg[1:0])
              2'h0: mode <= sms_pkg::SMS_NORMAL;
              2'h1: mode <= sms_pkg::SMS_STANDBY;
              2'h2: mode <= sms_pkg::SMS_STOP;
              2'h3: mode <= sms_pkg::SMS_SLEEP;
            endcase
          end
        end
        sms_pkg::SMS_STOP: if (wake_ev || cs_rise) begin
          mode  <= sms_pkg::SMS_NORMAL_REQ;
          tmr_q <= 24'(`SMS_NRQ_CYCLES);
        end
        sms_pkg::SMS_SLEEP: if (wake_ev) begin
          mode         <= sms_pkg::SMS_RESET;
          tmr_q        <= 24'(`SMS_RST_DUR_CYC);
          from_sleep_q <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************************************
  // wake pulse, outputs, high-side timer
  // ****************************************************************
  logic [8:0] pulse_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pulse_q <= 9'h000;
    end else if (mode == sms_pkg::SMS_STOP && (wake_ev || cs_rise)) begin
      pulse_q <= 9'(`SMS_IRQ_PULSE_CYC);
    end else if (pulse_q != 9'h000) begin
      pulse_q <= pulse_q - 9'h001;
    end
  end
  logic [11:0] hs_tmr_q;
  always_ff @(posedge ref_clk) begin
    if (rst || hs_tmr_q == 12'(`SMS_HS_PERIOD_CYC - 1)) begin
      hs_tmr_q <= 12'h000;
    end else begin
      hs_tmr_q <= hs_tmr_q + 12'h001;
    end
  end
  logic low_power;
  assign low_power = (mode == sms_pkg::SMS_STOP ||
                      mode == sms_pkg::SMS_SLEEP);
  assign slow_osc_sel = low_power;
  assign high_side_switch = hs_ctrl_q &&
         (!low_power || hs_tmr_q < 12'(`SMS_HS_ON_CYC));
  assign ballast_drive_out = (mode == sms_pkg::SMS_NORMAL);
  assign main_regulator_on = (mode != sms_pkg::SMS_SLEEP);
  assign sys_reset_out_n = (mode != sms_pkg::SMS_RESET) &&
                           !an_s.main_uv;
  assign irq_out_n = !(|(irq_flags_q & irq_en_q)) &&
                     (pulse_q == 9'h000);
  assign supervisor_fault_out_n = ~wdog_misservice;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_reset_low;
    @(posedge ref_clk) disable iff (rst)
      mode == sms_pkg::SMS_RESET |-> !sys_reset_out_n;
  endproperty
  a_reset_low: assert property (p_reset_low)
    else $error("reset output high in reset mode");
  property p_uv;
    @(posedge ref_clk) disable iff (rst) an_s.main_uv |-> !sys_reset_out_n;
  endproperty
  a_uv: assert property (p_uv)
    else $error("reset output high under undervoltage");
  property p_tx;
    @(posedge ref_clk) disable iff (rst)
      $fell(txd_s) |-> bus_drive_dominant;
  endproperty
  a_tx: assert property (p_tx)
    else $error("bus not dominant after transmit low");
  property p_irq_hold;
    @(posedge ref_clk) disable iff (rst)
      (|(irq_flags_q & irq_en_q) && !clr_hit) |=> !irq_out_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq released before clear");
  sequence s_stop_wake;
    mode == sms_pkg::SMS_STOP && (wake_ev || cs_rise);
  endsequence
  property p_wake_pulse;
    @(posedge ref_clk) disable iff (rst)
      s_stop_wake |=> (pulse_q != 9'h000)[*8] ##[1:200] (pulse_q == 9'h000);
  endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake pulse length wrong");
  property p_batt;
    @(posedge ref_clk) disable iff (rst)
      an_s.batt_loss |=> battery_loss_flag_q;
  endproperty
  a_batt: assert property (p_batt)
    else $error("battery loss not latched");
  property p_osc;
    @(posedge ref_clk) disable iff (rst)
      slow_osc_sel == (mode == sms_pkg::SMS_STOP ||
                       mode == sms_pkg::SMS_SLEEP);
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator selection wrong");
  property p_standby;
    @(posedge ref_clk) disable iff (rst)
      mode == sms_pkg::SMS_STANDBY |-> !ballast_drive_out && main_regulator_on;
  endproperty
  a_standby: assert property (p_standby)
    else $error("ballast drive on in standby");
  property p_stop_entry;
    @(posedge ref_clk) disable iff (rst)
      $changed(mode) && mode == sms_pkg::SMS_STOP |-> $past(cs_rise);
  endproperty
  a_stop_entry: assert property (p_stop_entry)
    else $error("stop entered outside select rising edge");
endmodule // sms_mode_supervisor

/* File: sim/sms_mcu_model.sv */
/*
 * microcontroller model: serial master and the bus wire.
 * assumes ref_clk at 20 MHz; the bench calls task xfer.
 */
module sms_mcu_model (
  input  wire logic         ref_clk,
  output sms_pkg::sms_spi_s spi_out,
  input  wire logic         spi_miso,
  input  wire logic         bus_drive_dominant,
  output logic              bus_dominant_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // serial master, sclk idle low
  // ****************************************
  initial begin
    spi_out = '{sclk: 1'b0, mosi: 1'b0, cs_n: 1'b1};
    bus_dominant_in = 1'b0;
  end
  // bus wire follows the transceiver drive
  always @(posedge ref_clk) begin
    bus_dominant_in <= bus_drive_dominant;
  end
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    @(posedge ref_clk);
    spi_out.cs_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    for (int i = 7; i >= 0; i--) begin
      rx[i] = spi_miso;
      spi_out.sclk <= 1'b1;
      spi_out.mosi <= tx[i];
      repeat (4) @(posedge ref_clk);
      spi_out.sclk <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    spi_out.cs_n <= 1'b1;
    spi_out.mosi <= ~tx[0];
    repeat (10) @(posedge ref_clk);
  endtask
endmodule // sms_mcu_model

/* File: sim/sms_mode_supervisor_tb.sv */
/*
 * self-checking bench of the mode supervisor.
 * assumes the design files and sms_mcu_model are compiled first.
 */
`include "sms_map.svh"
module sms_mode_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 ref_clk = 1'b0;
  logic                 rst = 1'b1;
  sms_pkg::sms_spi_s    spi;
  logic                 miso, miso_oe, rx_out, drv_dom, dom_in;
  logic                 tx_in = 1'b1;
  sms_pkg::sms_analog_s ana = '0;
  logic [3:0]           wake = 4'hF;
  logic                 missrv = 1'b0;
  logic                 rst_n, irq_n, fault_n, hs, ballast, main_on, slow;
  sms_pkg::sms_mode_e   mode;
  int                   miscompares = 0;
  int                   n_compared = 0;
  int                   n;
  logic [7:0]           v;

  always #25 ref_clk = ~ref_clk;

  sms_mode_supervisor sms_mode_supervisor_i (
    .ref_clk(ref_clk), .rst(rst), .spi_in(spi), .spi_miso(miso),
    .spi_miso_oe(miso_oe), .bus_transmit_in(tx_in),
    .bus_receive_out(rx_out), .bus_drive_dominant(drv_dom),
    .bus_dominant_in(dom_in), .bus_wake_in(1'b0), .analog_in(ana),
    .wake_inputs(wake), .wdog_misservice(missrv),
    .sys_reset_out_n(rst_n), .irq_out_n(irq_n),
    .supervisor_fault_out_n(fault_n), .high_side_switch(hs),
    .ballast_drive_out(ballast), .main_regulator_on(main_on),
    .slow_osc_sel(slow), .mode(mode));
  sms_mcu_model sms_mcu_model_i (
    .ref_clk(ref_clk), .spi_out(spi), .spi_miso(miso),
    .bus_drive_dominant(drv_dom), .bus_dominant_in(dom_in));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string w, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [3:0] a);
    logic [7:0] r;
    sms_mcu_model_i.xfer({c, a}, r);
  endtask
  // read data comes in the frame after the read command
  task automatic rd(input logic [3:0] c, output logic [7:0] r);
    cmd(c, 4'h0);
    sms_mcu_model_i.xfer({c, 4'h0}, r);
  endtask
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    cyc(20000);
    miscompares++;
    summarize();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    cyc(12);
    chk("rst_n", 8'(rst_n), 8'h00);
    chk("irq_n", 8'(irq_n), 8'h01);
    rst <= 1'b0;
    n = 0;
    while (mode !== sms_pkg::SMS_NORMAL_REQ && n < 1100) begin
      cyc(1);
      n++;
    end
    chk("rst_len", 8'(n >= 995 && n <= 1010), 8'h01);
    chk("rst_n", 8'(rst_n), 8'h01);
    chk("slow", 8'(slow), 8'h00);
    rd(`SMS_CMD_READ_MCR, v);
    chk("batt_loss", 8'(v[7]), 8'h01);
    $display("test reset done");
    for (int b = 0; b < 2; b++) begin
      tx_in <= b[0];
      cyc(8);
      chk("bus_dom", 8'(drv_dom), 8'(!b[0]));
      chk("bus_rx", 8'(rx_out), 8'(b[0]));
    end
    $display("test bus done");
    cmd(`SMS_CMD_WDOG, 4'h0);
    chk("mode", {5'h00, mode}, {5'h00, sms_pkg::SMS_NORMAL});
    chk("ballast", 8'(ballast), 8'h01);
    chk("main_on", 8'(main_on), 8'h01);
    $display("test normal done");
    wake <= 4'hA;
    ana.aux_low <= 1'b1;
    ana.hs_overtemp <= 1'b1;
    cyc(8);
    rd(`SMS_CMD_READ_IO, v);
    chk("io", v, 8'hAC);
    rd(`SMS_CMD_READ_IRQ, v);
    chk("irq_reg", v, 8'h04);
    cmd(`SMS_CMD_IRQ_EN, 4'h4);
    ana.aux_low <= 1'b0;
    ana.hs_overtemp <= 1'b0;
    cyc(8);
    chk("irq_n", 8'(irq_n), 8'h00);
    cmd(`SMS_CMD_CLR, 4'h4);
    chk("irq_n", 8'(irq_n), 8'h01);
    ana.main_temp_warn <= 1'b1;
    cyc(8);
    ana.main_temp_warn <= 1'b0;
    rd(`SMS_CMD_READ_IRQ, v);
    chk("irq_reg", v, 8'h01);
    cmd(`SMS_CMD_CLR, 4'h1);
    rd(`SMS_CMD_READ_IRQ, v);
    chk("irq_reg", v, 8'h00);
    $display("test flags done");
    missrv <= 1'b1;
    cyc(4);
    chk("fault_n", 8'(fault_n), 8'h00);
    missrv <= 1'b0;
    cyc(4);
    chk("fault_n", 8'(fault_n), 8'h01);
    $display("test fault done");
    wake <= 4'hF;
    cmd(`SMS_CMD_MODE, 4'h1);
    chk("mode", {5'h00, mode}, {5'h00, sms_pkg::SMS_STANDBY});
    chk("ballast", 8'(ballast), 8'h00);
    cmd(`SMS_CMD_HSW, 4'h1);
    chk("hs", 8'(hs), 8'h01);
    cmd(`SMS_CMD_MODE, 4'h2);
    chk("mode", {5'h00, mode}, {5'h00, sms_pkg::SMS_STOP});
    chk("slow", 8'(slow), 8'h01);
    wake <= 4'hE;
    n = 0;
    while (irq_n !== 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (irq_n === 1'b0 && n < 400) begin
      cyc(1);
      n++;
    end
    chk("pulse", 8'(n), 8'(`SMS_IRQ_PULSE_CYC));
    chk("mode", {5'h00, mode}, {5'h00, sms_pkg::SMS_NORMAL_REQ});
    wake <= 4'hF;
    $display("test stop done");
    ana.main_uv <= 1'b1;
    cyc(8);
    chk("rst_n", 8'(rst_n), 8'h00);
    $display("test undervoltage done");
    summarize();
  end
endmodule // sms_mode_supervisor_tb
